// ### verification/phy_management_access_tb.sv
`timescale 1ns/1ps
`include "phy_mgmt_params.svh"
module phy_management_access_tb;
  logic        i_clk = 0, i_rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, mdio_out, mdio_oe_b, mdc, int_sel;
  logic        phy_drv, phy_bit, mdio_wire, last_wr;
  logic [7:0]  frames;
  logic [4:0]  last_phy, last_reg;
  logic [15:0] last_data;
  int          err_count = 0, checked = 0, cyc = 0, n;

  // Pull-up wins when neither side drives
  assign mdio_wire = !mdio_oe_b ? mdio_out : (phy_drv ? phy_bit : 1'b1);

  phy_management_access i_phy_management_access (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_mdio(mdio_wire), .o_mdio(mdio_out), .o_mdio_oe_b(mdio_oe_b),
    .o_mdc(mdc), .o_int_phy_sel(int_sel));

  phy_mgmt_model i_phy_mgmt_model (.i_mdc(mdc), .i_mdio(mdio_wire),
    .o_drive(phy_drv), .o_bit(phy_bit), .o_frames(frames),
    .o_last_wr(last_wr), .o_last_phy(last_phy), .o_last_reg(last_reg),
    .o_last_data(last_data));

  // Clock and hang guard
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    @(posedge i_clk);
    while (pready !== 1'b1)
      @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Poll busy; n returns elapsed cycles
  task automatic wait_idle();
    int t0;
    t0 = cyc;
    do apb(0, `ACC_ADDR, 0);
    while (rd[0] !== 1'b0 && cyc - t0 < 8000);
    n = cyc - t0;
    chk("busy cleared", rd[0], 0);
  endtask

  task automatic t_reset();
    apb(0, `ACC_ADDR, 0); chk("acc reset", rd, 0);
    apb(0, `DATA_ADDR, 0); chk("data reset", rd, 0);
    chk("mapped no err", err, 0);
    apb(0, 8'h20, 0); chk("unmapped err", err, 1);
  endtask

  task automatic t_idle();
    apb(1, `ACC_ADDR, 32'h0000_08C2);
    repeat (300) @(posedge i_clk);
    chk("no frame", frames, 0);
    chk("mdc idle", mdc, 0);
    apb(0, `ACC_ADDR, 0); chk("acc fields", rd, 32'h0000_08C2);
  endtask

  task automatic t_write();
    apb(1, `DATA_ADDR, 32'h1234_ABCD);
    apb(0, `DATA_ADDR, 0); chk("data low half", rd, 32'h0000_ABCD);
    apb(1, `ACC_ADDR, 32'h0000_08C3);
    apb(0, `ACC_ADDR, 0); chk("busy set", rd[0], 1);
    chk("internal sel", int_sel, 1);
    apb(1, `DATA_ADDR, 32'h0000_5555);
    wait_idle();
    chk("busy time", (n > 6300 && n < 6600), 1);
    chk("frames", frames, 1);
    chk("op write", last_wr, 1);
    chk("phy addr", last_phy, 1);
    chk("reg index", last_reg, 3);
    chk("wire data", last_data, 16'hABCD);
    apb(0, `DATA_ADDR, 0); chk("data kept", rd, 32'h0000_ABCD);
  endtask

  task automatic t_read();
    apb(1, `ACC_ADDR, 32'h0000_97C1);
    apb(0, `ACC_ADDR, 0); chk("busy read", rd[0], 1);
    chk("external sel", int_sel, 0);
    wait_idle();
    chk("op read", last_wr, 0);
    chk("reg index", last_reg, 5'h1F);
    chk("phy addr ext", last_phy, 5'h12);
    chk("frames two", frames, 2);
    apb(0, `DATA_ADDR, 0);
    chk("read data", rd, {16'h0000, 5'h1F, 5'h12, 6'h2D});
  endtask

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence after 20 reset cycles
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1;
    t_reset();
    t_idle();
    t_write();
    t_read();
    wrap_up();
  end
endmodule // phy_management_access_tb

// ### verification/phy_mgmt_model.sv
`timescale 1ns/1ps
// Behavioural PHY management port; answers reads, records writes
module phy_mgmt_model (
  input  wire logic i_mdc,
  input  wire logic i_mdio,
  output logic      o_drive,
  output logic      o_bit,
  output logic [7:0]  o_frames,
  output logic        o_last_wr,
  output logic [4:0]  o_last_phy,
  output logic [4:0]  o_last_reg,
  output logic [15:0] o_last_data
);
  logic [5:0]  pos;
  logic        busy_q;
  logic [31:0] sh;
  logic [15:0] rword;

  initial begin
    {pos, busy_q, sh, rword} = '0;
    {o_drive, o_bit, o_frames, o_last_wr} = '0;
    {o_last_phy, o_last_reg, o_last_data} = '0;
  end

  // Sample on rising clock; a zero after ones marks the start
  always @(posedge i_mdc) begin
    sh = {sh[30:0], i_mdio};
    if (!busy_q) begin
      if (i_mdio === 1'b0) begin
        busy_q = 1'b1;
        pos = 6'd33;
      end
    end else begin
      if (pos == 6'd45) begin
        o_last_wr  = (sh[11:10] == 2'b01);
        o_last_phy = sh[9:5];
        o_last_reg = sh[4:0];
        rword      = {sh[4:0], sh[9:5], 6'h2D};
      end
      if (pos == 6'd63) begin
        o_frames = o_frames + 8'd1;
        if (o_last_wr) o_last_data = sh[15:0];
        busy_q = 1'b0;
      end
      pos = pos + 6'd1;
    end
  end

  // Turnaround zero then data, changed on falling clock; released after
  always @(negedge i_mdc) begin
    o_drive = busy_q && !o_last_wr && (pos >= 6'd47);
    o_bit   = (pos == 6'd47) ? 1'b0 : rword[4'(6'd63 - pos)];
  end
endmodule // phy_mgmt_model

// ### verilog/mdio_frame_engine.sv
`timescale 1ns/1ps
`include "phy_mgmt_params.svh"
module mdio_frame_engine (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic [4:0]  i_phy_addr,
  input  wire logic [4:0]  i_reg_index,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_mdio,
  output logic             o_mdc,
  output logic             o_mdio,
  output logic             o_mdio_oe_b,
  output logic             o_done,
  output logic [15:0]      o_rdata
);
  import phy_mgmt_pkg::*;

  localparam logic [5:0] HALF_LAST = 6'(`MDC_HALF_CYC - 1);

  mf_state_type state_q, state_d;
  logic [63:0]  frame_q, frame_d;
  logic [5:0]   bit_q, bit_d, phase_q, phase_d, nbit;
  logic         mdc_q, mdc_d, mdio_q, mdio_d, oe_b_q, oe_b_d;
  logic         done_q, done_d, write_q, write_d;
  logic [15:0]  rdata_q, rdata_d;
  logic         sync1_q, sync2_q;

  // Pin synchroniser; only the second stage feeds logic
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= i_mdio;
      sync2_q <= sync1_q;
    end
  end

  // Frame sequencer: drive on falling MDC, sample on rising MDC
  always_comb begin
    state_d = state_q;
    frame_d = frame_q;
    bit_d   = bit_q;
    phase_d = phase_q;
    mdc_d   = mdc_q;
    mdio_d  = mdio_q;
    oe_b_d  = oe_b_q;
    write_d = write_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    nbit    = bit_q + 6'h01;
    unique case (state_q)
      MF_IDLE: begin
        mdc_d  = 1'b0;
        oe_b_d = 1'b1;
        if (i_start) begin
          frame_d = {`MF_PREAMBLE, `MF_START,                        // R10
                     i_write ? `MF_OP_WRITE : `MF_OP_READ,          // R03
                     i_phy_addr, i_reg_index,                       // R01 R02
                     i_write ? `MF_TA_WRITE : `MF_TA_READ,
                     i_write ? i_wdata : `MF_RD_FILL};
          write_d = i_write;
          bit_d   = 6'h00;
          phase_d = 6'h00;
          mdio_d  = 1'b1;
          oe_b_d  = 1'b0;
          state_d = MF_RUN;
        end
      end
      MF_RUN: begin
        if (phase_q == HALF_LAST) begin
          phase_d = 6'h00;
          mdc_d   = ~mdc_q;                                         // R10
          if (!mdc_q) begin
            // Rising edge: PHY data has been stable for a half period
            if (!write_q && bit_q >= `MF_DATA_FIRST)
              rdata_d = {rdata_q[14:0], sync2_q};                   // R03
          end else if (bit_q == `MF_LAST_BIT) begin
            done_d  = 1'b1;                                         // R05
            oe_b_d  = 1'b1;
            state_d = MF_IDLE;
          end else begin
            bit_d  = nbit;
            mdio_d = frame_q[~nbit];
            oe_b_d = !write_q && nbit >= `MF_TA_FIRST;              // R10
          end
        end else begin
          phase_d = phase_q + 6'h01;
        end
      end
      default: begin
        state_d = MF_IDLE;
        oe_b_d  = 1'b1;
      end
    endcase
  end

  // Frame sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= MF_IDLE;
      frame_q <= 64'h0000_0000_0000_0000;
      bit_q   <= 6'h00;
      phase_q <= 6'h00;
      mdc_q   <= 1'b0;
      mdio_q  <= 1'b1;
      oe_b_q  <= 1'b1;
      write_q <= 1'b0;
      rdata_q <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      frame_q <= frame_d;
      bit_q   <= bit_d;
      phase_q <= phase_d;
      mdc_q   <= mdc_d;
      mdio_q  <= mdio_d;
      oe_b_q  <= oe_b_d;
      write_q <= write_d;
      rdata_q <= rdata_d;
      done_q  <= done_d;
    end
  end

  assign o_mdc       = mdc_q;
  assign o_mdio      = mdio_q;
  assign o_mdio_oe_b = oe_b_q;
  assign o_done      = done_q;
  assign o_rdata     = rdata_q;

  a_phy_addr_load: assert property ( // R01
    @(posedge i_clk) disable iff (!i_rst_b)
    state_q == MF_IDLE && i_start |=> frame_q[27:23] == $past(i_phy_addr))
    else $error("phy address not placed in frame");
  a_reg_index_load: assert property ( // R02
    @(posedge i_clk) disable iff (!i_rst_b)
    state_q == MF_IDLE && i_start |=> frame_q[22:18] == $past(i_reg_index))
    else $error("register index not placed in frame");
  a_op_code_sel: assert property ( // R03
    @(posedge i_clk) disable iff (!i_rst_b)
    state_q == MF_IDLE && i_start && i_write |=>
    frame_q[29:28] == `MF_OP_WRITE && frame_q[15:0] == $past(i_wdata))
    else $error("write frame opcode or data wrong");
  a_turnaround_rel: assert property ( // R10
    @(posedge i_clk) disable iff (!i_rst_b)
    state_q == MF_RUN && !write_q && bit_q >= `MF_TA_FIRST |-> oe_b_q)
    else $error("line driven during read turnaround");
  a_mdc_idle_low: assert property ( // R10
    @(posedge i_clk) disable iff (!i_rst_b)
    state_q == MF_IDLE |=> !mdc_q)
    else $error("management clock runs while idle");
endmodule // mdio_frame_engine

// ### verilog/phy_management_access.sv
//
// What this block does
// R01: PHY address from access bits 15-11; address 00001b is internal.
// R02: Register index from access bits 10-6 selects PHY register.
// R03: Write-select one writes data register to PHY; zero reads into it.
// R04: Access starts only when software writes busy bit one.
// R05: Busy stays one during the access and clears when it completes.
// R06: Software polls busy zero before writing access or data register.
// R07: Software keeps data register unchanged during a PHY write.
// R08: Read data invalid until busy clears; software waits for it.
// R09: Data register holds 16-bit value in low half; upper bits reserved.
// R10: Access runs as a clause 22 MDC/MDIO frame with read turnaround.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "phy_mgmt_params.svh"
module phy_management_access (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_mdio,
  output logic             o_mdio,
  output logic             o_mdio_oe_b,
  output logic             o_mdc,
  output logic             o_int_phy_sel
);
  import phy_mgmt_pkg::*;

  logic [4:0]  phy_addr_q, phy_addr_d, reg_index_q, reg_index_d;
  logic        write_sel_q, write_sel_d, busy_q, busy_d;
  logic        start_q, start_d, int_sel_q, int_sel_d;
  logic [15:0] data_q, data_d;
  logic [31:0] prdata_q, prdata_d, acc_word;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic        fire, wr_acc, wr_data, done;
  logic [15:0] rdata;

  // Decode of one register word, shared by read and write paths
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // One wait state lets every bus output come from a flop
  assign fire    = i_psel && i_penable && pready_q;
  // Writes while busy are dropped so a running frame is never corrupted
  assign wr_acc  = fire && i_pwrite && hit(i_paddr, `ACC_ADDR) && !busy_q;
  assign wr_data = fire && i_pwrite && hit(i_paddr, `DATA_ADDR) && !busy_q;
  assign acc_word = {16'h0000, phy_addr_q, reg_index_q, 4'h0,
                     write_sel_q, busy_q};

  // APB slave answer path
  always_comb begin
    pready_d  = i_psel && i_penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    if (pready_d) begin
      if (hit(i_paddr, `ACC_ADDR))
        prdata_d = acc_word;
      else if (hit(i_paddr, `DATA_ADDR))
        prdata_d = {16'h0000, data_q};                              // R09
      else
        pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `REG_RESET;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // Access and data registers, busy handshake
  always_comb begin
    phy_addr_d  = phy_addr_q;
    reg_index_d = reg_index_q;
    write_sel_d = write_sel_q;
    busy_d      = busy_q;
    data_d      = data_q;
    start_d     = 1'b0;
    if (wr_acc) begin
      phy_addr_d  = i_pwdata[`ACC_PHY_MSB:`ACC_PHY_LSB];            // R01
      reg_index_d = i_pwdata[`ACC_REG_MSB:`ACC_REG_LSB];            // R02
      write_sel_d = i_pwdata[`ACC_WR_BIT];                          // R03
      busy_d      = i_pwdata[`ACC_BUSY_BIT];                        // R04
      start_d     = i_pwdata[`ACC_BUSY_BIT];                        // R04
    end
    if (wr_data)
      data_d = i_pwdata[`DATA_MSB:0];                               // R09
    if (done && busy_q) begin
      busy_d = 1'b0;                                                // R05
      if (!write_sel_q)
        data_d = rdata;                                             // R03 R08
    end
    int_sel_d = busy_d && (phy_addr_d == `INT_PHY_ADDR);            // R01
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      phy_addr_q  <= 5'h00;
      reg_index_q <= 5'h00;
      write_sel_q <= 1'b0;
      busy_q      <= 1'b0;
      data_q      <= 16'h0000;
      start_q     <= 1'b0;
      int_sel_q   <= 1'b0;
    end else begin
      phy_addr_q  <= phy_addr_d;
      reg_index_q <= reg_index_d;
      write_sel_q <= write_sel_d;
      busy_q      <= busy_d;
      data_q      <= data_d;
      start_q     <= start_d;
      int_sel_q   <= int_sel_d;
    end
  end

  // Frame engine owns the management pins
  mdio_frame_engine u_engine (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_start     (start_q),
    .i_write     (write_sel_q),
    .i_phy_addr  (phy_addr_q),
    .i_reg_index (reg_index_q),
    .i_wdata     (data_q),
    .i_mdio      (i_mdio),
    .o_mdc       (o_mdc),
    .o_mdio      (o_mdio),
    .o_mdio_oe_b (o_mdio_oe_b),
    .o_done      (done),
    .o_rdata     (rdata)
  );

  assign o_prdata      = prdata_q;
  assign o_pready      = pready_q;
  assign o_pslverr     = pslverr_q;
  assign o_int_phy_sel = int_sel_q;

  // Checks on the access register and busy handshake
  a_busy_on_start: assert property ( // R04
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_acc && i_pwdata[`ACC_BUSY_BIT] |=> busy_q && start_q)
    else $error("busy write did not start access");
  a_start_needs_busy: assert property ( // R04
    @(posedge i_clk) disable iff (!i_rst_b)
    start_q |-> busy_q && $past(busy_q) == 1'b0)
    else $error("access started without busy set");
  a_busy_holds: assert property ( // R05
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && !done |=> busy_q)
    else $error("busy dropped before completion");
  a_busy_clears: assert property ( // R05
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && done |=> !busy_q)
    else $error("busy not cleared on completion");
  a_busy_locks_acc: assert property ( // R05
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && fire && i_pwrite |=> $stable(phy_addr_q) &&
    $stable(reg_index_q) && $stable(write_sel_q))
    else $error("access fields changed during access");
  a_phy_field_cap: assert property ( // R01
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_acc |=> phy_addr_q == $past(i_pwdata[`ACC_PHY_MSB:`ACC_PHY_LSB]))
    else $error("phy address field not captured");
  a_reg_field_cap: assert property ( // R02
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_acc |=> reg_index_q == $past(i_pwdata[`ACC_REG_MSB:`ACC_REG_LSB]))
    else $error("register index field not captured");
  a_write_sel_cap: assert property ( // R03
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_acc |=> write_sel_q == $past(i_pwdata[`ACC_WR_BIT]))
    else $error("write select not captured");
  a_int_phy_route: assert property ( // R01
    @(posedge i_clk) disable iff (!i_rst_b)
    o_int_phy_sel == (busy_q && phy_addr_q == `INT_PHY_ADDR))
    else $error("internal phy select wrong");

  // Checks on the data register
  a_read_capture: assert property ( // R03
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && done && !write_sel_q |=> data_q == $past(rdata))
    else $error("read result not captured");
  a_write_no_capture: assert property ( // R03
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && done && write_sel_q |=> $stable(data_q))
    else $error("data register changed after phy write");
  a_data_stable: assert property ( // R08
    @(posedge i_clk) disable iff (!i_rst_b)
    busy_q && !done |=> $stable(data_q))
    else $error("data register changed during access");
  a_data_load: assert property ( // R09
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_data |=> data_q == $past(i_pwdata[`DATA_MSB:0]))
    else $error("data register write not taken");

  // Checks on the bus answer
  a_data_upper_zero: assert property ( // R09
    @(posedge i_clk) disable iff (!i_rst_b)
    i_psel && i_penable && !pready_q && i_paddr == `DATA_ADDR
    |=> o_pready && o_prdata[31:16] == 16'h0000)
    else $error("data register upper half not zero");
  a_unmapped_err: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    i_psel && i_penable && !pready_q && !hit(i_paddr, `ACC_ADDR) &&
    !hit(i_paddr, `DATA_ADDR) |=> o_pslverr && o_prdata == `REG_RESET)
    else $error("unmapped address not refused");
  a_apb_one_wait: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_psel && i_penable) |-> !o_pready ##1 o_pready)
    else $error("bus answer not after one wait state");
endmodule // phy_management_access

// ### verilog/phy_mgmt_params.svh
`ifndef PHY_MGMT_PARAMS_SVH
`define PHY_MGMT_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACC_INDEX       8'h06
`define DATA_INDEX      8'h07
`define ACC_ADDR        (8'(`ACC_INDEX * 4))
`define DATA_ADDR       (8'(`DATA_INDEX * 4))

// Access register fields
`define ACC_PHY_MSB     15
`define ACC_PHY_LSB     11
`define ACC_REG_MSB     10
`define ACC_REG_LSB     6
`define ACC_WR_BIT      1
`define ACC_BUSY_BIT    0
`define DATA_MSB        15
`define REG_RESET       32'h0000_0000
`define INT_PHY_ADDR    5'h01

// Management frame fields
`define MF_PREAMBLE     32'hFFFF_FFFF
`define MF_START        2'h1
`define MF_OP_READ      2'h2
`define MF_OP_WRITE     2'h1
`define MF_TA_WRITE     2'h2
`define MF_TA_READ      2'h3
`define MF_RD_FILL      16'hFFFF
`define MF_TA_FIRST     6'h2E
`define MF_DATA_FIRST   6'h30
`define MF_LAST_BIT     6'h3F

// Timing: management clock period is a least time, rounded up
`define CLK_PERIOD_NS   4
`define MDC_PERIOD_NS   400
`define MDC_HALF_CYC    (((`MDC_PERIOD_NS / 2) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### verilog/phy_mgmt_pkg.sv
package phy_mgmt_pkg;
  typedef enum logic [1:0] {
    MF_IDLE = 2'h1,
    MF_RUN  = 2'h2
  } mf_state_type;
endpackage
